// *** include/sprs_pkg.sv ***
// package for the serial port role and interrupt select block
// assumes a 32-bit classic wishbone register bus and a single 250 MHz clock
//
// Notes on behaviour
// RL1: bit 5 high selects host role
// RL2: bit 4 high releases serial input pin
// RL3: tx select 11 free slot, 10 half empty
// RL4: tx select 01 empty, 00 shifting finished
// RL5: rx select 11 full, 10 half full
// RL6: rx select 01 not empty, 00 last read
// RL7: software avoids access right after disable
// RL8: some fields writable only while disabled
// RL9: software zeroes ignored field in framed mode
// RL10: audio mode forces idle polarity high
// RL11: irq requests recomputed every clock cycle
package sprs_pkg;
  // register byte offsets
  localparam logic [3:0] SPRS_CTRL_OFS = 4'h0;
  localparam logic [3:0] SPRS_DATA_OFS = 4'h4;
  localparam logic [3:0] SPRS_STAT_OFS = 4'h8;
  // control field positions
  localparam int SPRS_RXSEL_LO = 0;
  localparam int SPRS_TXSEL_LO = 2;
  localparam int SPRS_SDI_REL_BIT = 4;
  localparam int SPRS_HOST_BIT = 5;
  localparam int SPRS_CKP_BIT = 6;
  localparam int SPRS_WIDE_BIT = 7;
  localparam int SPRS_AUDIO_BIT = 13;
  localparam int SPRS_FRAMED_BIT = 14;
  localparam int SPRS_ON_BIT = 15;
  // reset value and mask of locked fields (host, ckp, audio, framed)
  localparam logic [15:0] SPRS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] SPRS_LOCK_MASK = 16'h6060;
  localparam logic [15:0] SPRS_CTRL_MASK = 16'hE0FF;
  // link clock divider for host role
  localparam logic [7:0] SPRS_HALF_DIV = 8'h04;
  localparam logic [4:0] SPRS_BITS = 5'h08;
  // buffer occupancy thresholds for two entries
  localparam logic [1:0] SPRS_DEPTH = 2'h2;
  localparam logic [1:0] SPRS_HALF = 2'h1;

  // irq select encodings
  typedef enum logic [1:0] {
    SPRS_SEL_00 = 2'h0,
    SPRS_SEL_01 = 2'h1,
    SPRS_SEL_10 = 2'h2,
    SPRS_SEL_11 = 2'h3
  } sprs_sel_t;

  // control register fields
  typedef struct packed {
    logic on;
    logic framed;
    logic audio;
    logic [4:0] rsvd;
    logic wide;
    logic clock_idle_polarity;
    logic host;
    logic sdi_release;
    logic [1:0] tx_irq_condition;
    logic [1:0] rx_irq_condition;
  } sprs_ctrl_t;

  // serial pin group
  typedef struct packed {
    logic sck;
    logic sdo;
  } sprs_pins_t;
endpackage

// *** core/sprs_fifo.sv ***
// two-entry buffer with valid and ready on both sides
// assumes fill and drain on the same clock
`timescale 1ns/1ps
module sprs_fifo import sprs_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [1:0] count_o
);
  // whole buffer state
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] count;
  } sprs_fifo_st_t;
  sprs_fifo_st_t st_reg, st_next;
  logic push, pop;

  assign in_ready_o = (st_reg.count != SPRS_DEPTH);
  assign out_valid_o = (st_reg.count != 2'h0);
  assign out_data_o = st_reg.mem[0];
  assign count_o = st_reg.count;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // shift-out buffer: entry 0 is head
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.mem[0] = st_reg.mem[1];
    end
    if (push) begin
      // write lands behind what remains
      if (st_reg.count - {1'b0, pop} == 2'h0) begin
        st_next.mem[0] = in_data_i;
      end else begin
        st_next.mem[1] = in_data_i;
      end
    end
    st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// *** core/sprs_core.sv ***
// serial port controller: role select, pin release and irq conditions
// assumes classic wishbone master; link pins are asynchronous to clk_i
`timescale 1ns/1ps
module sprs_core import sprs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  output logic sdo_o,
  input wire logic ss_n_i,
  output logic sdi_owned_o,
  // interrupt requests
  output logic tx_irq_o,
  output logic rx_irq_o
);
  // all core state except the two buffers in one record
  typedef struct packed {
    sprs_ctrl_t ctrl;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [1:0] ss_sync;
    logic sck_prev;
    logic busy;
    logic [4:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] div;
    logic sck_gen;
    logic sck_out;
    logic sck_oe;
    logic sdo;
    logic sdi_own;
    logic done;
    logic last_read;
    logic tx_irq;
    logic rx_irq;
  } sprs_st_t;
  sprs_st_t st_reg, st_next;

  // buffer handshakes
  logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
  logic tx_pop, rx_push, rx_pop, tx_push;
  logic [7:0] tx_head, rx_head;
  logic [1:0] tx_count, rx_count;
  // decoded bus request
  logic req, wr_ctrl, wr_data, rd_data;
  // effective idle polarity and link edges
  logic ckp_eff, lead_edge, trail_edge, sck_now;
  logic [7:0] rx_word;

  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr_ctrl = req && wb_we_i && wb_adr_i == SPRS_CTRL_OFS;
  assign wr_data = req && wb_we_i && wb_adr_i == SPRS_DATA_OFS && wb_sel_i[0];
  assign rd_data = req && !wb_we_i && wb_adr_i == SPRS_DATA_OFS;
  assign tx_push = wr_data && st_reg.ctrl.on;
  assign rx_pop = rd_data && rx_out_valid;

  // audio mode behaves as idle-high clock [RL10]
  assign ckp_eff = st_reg.ctrl.audio ? 1'b1 : st_reg.ctrl.clock_idle_polarity;

  // in host role the internal divider drives the clock, else the pin [RL1]
  assign sck_now = st_reg.ctrl.host ? st_reg.sck_gen : st_reg.sck_sync[1];
  assign lead_edge = (sck_now != st_reg.sck_prev) && (sck_now != ckp_eff);
  assign trail_edge = (sck_now != st_reg.sck_prev) && (sck_now == ckp_eff);

  // shift engine pulls a word when idle
  assign tx_pop = !st_reg.busy && st_reg.ctrl.on && tx_out_valid && rx_in_ready &&
    (st_reg.ctrl.host || !st_reg.ss_sync[1]);
  // released input pin samples as zero [RL2]
  assign rx_word = {st_reg.shreg[6:0],
    st_reg.ctrl.sdi_release ? 1'b0 : st_reg.sdi_sync[1]};
  assign rx_push = st_reg.busy && lead_edge && st_reg.bitcnt == SPRS_BITS - 5'h1;

  sprs_fifo #(.WIDTH(8)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_ready),
    .in_data_i(wb_dat_i[7:0]),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_pop),
    .out_data_o(tx_head),
    .count_o(tx_count)
  );

  sprs_fifo #(.WIDTH(8)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(rx_word),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_head),
    .count_o(rx_count)
  );

  // next-state logic
  always_comb begin
    st_next = st_reg;
    // pin synchronisers, first stage read only by second
    st_next.sck_sync = {st_reg.sck_sync[0], sck_i};
    st_next.sdi_sync = {st_reg.sdi_sync[0], sdi_i};
    st_next.ss_sync = {st_reg.ss_sync[0], ss_n_i};
    st_next.sck_prev = sck_now;
    // bus answer one cycle after request
    st_next.ack = req;
    st_next.rdata = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        SPRS_CTRL_OFS: st_next.rdata = {16'h0000, st_reg.ctrl & SPRS_CTRL_MASK};
        SPRS_DATA_OFS: st_next.rdata = {24'h00_0000, rx_head};
        SPRS_STAT_OFS: st_next.rdata = {24'h00_0000, st_reg.busy, st_reg.done,
          rx_count, tx_count, tx_in_ready, rx_out_valid};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // control write, locked fields held while enabled [RL8]
    if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        st_next.ctrl[7:0] = wb_dat_i[7:0];
        if (st_reg.ctrl.on) begin
          st_next.ctrl.host = st_reg.ctrl.host;
          st_next.ctrl.clock_idle_polarity = st_reg.ctrl.clock_idle_polarity;
        end
      end
      if (wb_sel_i[1]) begin
        st_next.ctrl[15:8] = wb_dat_i[15:8] & SPRS_CTRL_MASK[15:8];
        if (st_reg.ctrl.on) begin
          st_next.ctrl.audio = st_reg.ctrl.audio;
          st_next.ctrl.framed = st_reg.ctrl.framed;
        end
      end
    end
    // host clock divider, only while a word shifts
    if (st_reg.ctrl.host && st_reg.busy) begin
      if (st_reg.div == SPRS_HALF_DIV - 8'h01) begin
        st_next.div = 8'h00;
        st_next.sck_gen = !st_reg.sck_gen;
      end else begin
        st_next.div = st_reg.div + 8'h01;
      end
    end else begin
      st_next.div = 8'h00;
      st_next.sck_gen = ckp_eff;
    end
    // host drives clock pin, target leaves it [RL1]
    st_next.sck_oe = st_reg.ctrl.on && st_reg.ctrl.host;
    st_next.sck_out = st_reg.sck_gen;
    st_next.sdi_own = st_reg.ctrl.on && !st_reg.ctrl.sdi_release; // [RL2]
    // word shifting
    if (tx_pop) begin
      st_next.busy = 1'b1;
      st_next.shreg = tx_head;
      st_next.sdo = tx_head[7];
      st_next.bitcnt = 5'h00;
      st_next.done = 1'b0;
    end else if (st_reg.busy) begin
      if (lead_edge) begin
        st_next.shreg = rx_word;
        st_next.bitcnt = st_reg.bitcnt + 5'h01;
      end
      if (trail_edge && st_reg.bitcnt != 5'h00) begin
        if (st_reg.bitcnt == SPRS_BITS) begin
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
        end else begin
          st_next.sdo = st_reg.shreg[7];
        end
      end
    end
    if (!st_reg.ctrl.on) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b0;
    end
    // last buffered word read empties the buffer [RL6]
    st_next.last_read = rx_pop && rx_count == 2'h1;
    // irq conditions recomputed each cycle [RL11]
    unique case (sprs_sel_t'(st_reg.ctrl.tx_irq_condition))
      SPRS_SEL_11: st_next.tx_irq = tx_count != SPRS_DEPTH; // [RL3]
      SPRS_SEL_10: st_next.tx_irq = tx_count <= SPRS_HALF; // [RL3]
      SPRS_SEL_01: st_next.tx_irq = tx_count == 2'h0; // [RL4]
      SPRS_SEL_00: st_next.tx_irq = st_reg.done && tx_count == 2'h0; // [RL4]
    endcase
    unique case (sprs_sel_t'(st_reg.ctrl.rx_irq_condition))
      SPRS_SEL_11: st_next.rx_irq = rx_count == SPRS_DEPTH; // [RL5]
      SPRS_SEL_10: st_next.rx_irq = rx_count >= SPRS_HALF; // [RL5]
      SPRS_SEL_01: st_next.rx_irq = rx_count != 2'h0; // [RL6]
      SPRS_SEL_00: st_next.rx_irq = st_reg.last_read; // [RL6]
    endcase
    if (!st_reg.ctrl.on) begin
      st_next.tx_irq = 1'b0;
      st_next.rx_irq = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign sck_o = st_reg.sck_out;
  assign sck_oe_o = st_reg.sck_oe;
  assign sdo_o = st_reg.sdo;
  assign sdi_owned_o = st_reg.sdi_own;
  assign tx_irq_o = st_reg.tx_irq;
  assign rx_irq_o = st_reg.rx_irq;

  // checks
  // an enabled host drives the clock pin
  chk_host_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
    st_reg.ctrl.on && st_reg.ctrl.host |=> sck_oe_o)
    else $error("host role not driving clock");

  // a target never drives the clock pin
  chk_target_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
    !st_reg.ctrl.host |=> !sck_oe_o)
    else $error("target role driving clock");

  // while a word shifts, the host clock only moves when the divider wraps
  chk_host_div: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
    st_reg.ctrl.host && st_reg.busy && st_reg.div != SPRS_HALF_DIV - 8'h01
    |=> $stable(st_reg.sck_gen))
    else $error("host clock moved off the divider");

  // a released input is not owned
  chk_sdi_release: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
    st_reg.ctrl.sdi_release |=> !sdi_owned_o)
    else $error("released input still owned");

  // an enabled, kept input is owned
  chk_sdi_owned: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
    st_reg.ctrl.on && !st_reg.ctrl.sdi_release |=> sdi_owned_o)
    else $error("kept input not owned");

  // a released input shifts in zeros only
  chk_sdi_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
    st_reg.ctrl.sdi_release |-> rx_word[0] == 1'b0)
    else $error("released input bit not zero");

  // a full transmit buffer gives no free-slot request
  chk_tx_free: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    st_reg.ctrl.on && st_reg.ctrl.tx_irq_condition == 2'h3 && tx_count == SPRS_DEPTH
    |=> !tx_irq_o)
    else $error("tx irq while buffer full");

  // free-slot request follows occupancy
  chk_tx_free_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    st_reg.ctrl.on && st_reg.ctrl.tx_irq_condition == 2'h3
    |=> tx_irq_o == ($past(tx_count) != SPRS_DEPTH))
    else $error("tx free irq mismatch");

  // half-empty request follows occupancy
  chk_tx_half: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    st_reg.ctrl.on && st_reg.ctrl.tx_irq_condition == 2'h2
    |=> tx_irq_o == ($past(tx_count) <= SPRS_HALF))
    else $error("tx half irq mismatch");

  // empty request follows occupancy
  chk_tx_empty: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    st_reg.ctrl.on && st_reg.ctrl.tx_irq_condition == 2'h1
    |=> tx_irq_o == ($past(tx_count) == 2'h0))
    else $error("tx empty irq mismatch");

  // finished request needs the last word out and an empty buffer
  chk_tx_done: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    st_reg.ctrl.on && st_reg.ctrl.tx_irq_condition == 2'h0
    |=> tx_irq_o == ($past(st_reg.done) && $past(tx_count) == 2'h0))
    else $error("tx done irq mismatch");

  // full request follows occupancy
  chk_rx_full: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    st_reg.ctrl.on && st_reg.ctrl.rx_irq_condition == 2'h3
    |=> rx_irq_o == ($past(rx_count) == 2'h2))
    else $error("rx full irq mismatch");

  // half-full request follows occupancy
  chk_rx_half: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    st_reg.ctrl.on && st_reg.ctrl.rx_irq_condition == 2'h2
    |=> rx_irq_o == ($past(rx_count) >= SPRS_HALF))
    else $error("rx half irq mismatch");

  // not-empty request follows occupancy
  chk_rx_any: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    st_reg.ctrl.on && st_reg.ctrl.rx_irq_condition == 2'h1
    |=> rx_irq_o == ($past(rx_count) != 2'h0))
    else $error("rx not empty irq mismatch");

  // reading the last word pulses the request two cycles later
  chk_rx_last: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    st_reg.ctrl.on && st_reg.ctrl.rx_irq_condition == 2'h0 && $stable(st_reg.ctrl)
    && rx_pop && rx_count == 2'h1 |-> ##2 rx_irq_o)
    else $error("no irq on last read");

  // no last-read request without a last read
  chk_rx_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    st_reg.ctrl.on && st_reg.ctrl.rx_irq_condition == 2'h0 && !st_reg.last_read |=> !rx_irq_o)
    else $error("rx last read irq without a read");

  // a disabled block raises no request
  chk_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    !st_reg.ctrl.on |=> !tx_irq_o && !rx_irq_o)
    else $error("irq raised while disabled");

  // host role field holds while enabled
  chk_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    st_reg.ctrl.on |=> st_reg.ctrl.host == $past(st_reg.ctrl.host))
    else $error("locked field changed while enabled");

  // idle polarity is locked as well
  chk_lock_ckp: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    st_reg.ctrl.on |=> st_reg.ctrl.clock_idle_polarity == $past(st_reg.ctrl.clock_idle_polarity))
    else $error("idle polarity changed while enabled");

  // audio and framed mode enables are locked too
  chk_lock_mode: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    st_reg.ctrl.on |=> st_reg.ctrl.audio == $past(st_reg.ctrl.audio)
    && st_reg.ctrl.framed == $past(st_reg.ctrl.framed))
    else $error("mode enable changed while enabled");

  // audio mode idles the host clock high
  chk_audio_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
    st_reg.ctrl.host && st_reg.ctrl.audio && !st_reg.busy |=> st_reg.sck_gen)
    else $error("audio idle clock not high");
endmodule

// *** verification/sprs_peer.sv ***
// far-side serial device model: one byte each way per frame, msb first
// assumes idle-low clock, sample on rising, shift on falling edge
`timescale 1ns/1ps
module sprs_peer (
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic sdo_o,
  output logic sck_i,
  output logic sdi_i,
  output logic ss_n_i,
  output logic [7:0] rx_byte_o
);
  logic [7:0] sh_reg; // outgoing bits, msb on the line
  logic own_sck; // clock made here when the design is target
  wire logic sck_w = sck_oe_o ? sck_o : own_sck; // whoever drives the clock
  initial begin
    own_sck = 1'b0;
    ss_n_i = 1'b1;
    sh_reg = 8'h00;
    rx_byte_o = 8'h00;
  end
  assign sck_i = own_sck; // stands still outside frames
  // not selected: put the inverse so a stale bit never passes
  assign sdi_i = (sck_oe_o || !ss_n_i) ? sh_reg[7] : !sh_reg[7];
  // capture what the design sends
  always @(posedge sck_w) begin
    rx_byte_o <= {rx_byte_o[6:0], sdo_o};
  end
  // present the next bit
  always @(negedge sck_w) begin
    sh_reg <= {sh_reg[6:0], 1'b0};
  end
  // preload the byte to send
  task automatic load(input logic [7:0] b);
    sh_reg <= b;
  endtask
  // one target-mode frame at an 80 ns clock
  task automatic target_frame();
    // edges land on clock edges, so update after the design has sampled
    ss_n_i <= 1'b0;
    #40;
    repeat (8) begin
      own_sck <= 1'b1;
      #40;
      own_sck <= 1'b0;
      #40;
    end
    ss_n_i <= 1'b1;
  endtask
endmodule

// *** verification/spi_role_and_irq_select_test.sv ***
// self-checking bench: wishbone calls with expected values
// assumes the far-side model sprs_peer on the link pins
`timescale 1ns/1ps
module spi_role_and_irq_select_test import sprs_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0; // byte lanes
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] q; // last read data
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sck_i, sck_o, sck_oe_o, sdi_i, sdo_o, ss_n_i;
  logic sdi_owned_o, tx_irq_o, rx_irq_o, hit;
  logic [7:0] peer_rx;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  sprs_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(sdi_i), .sdo_o(sdo_o), .ss_n_i(ss_n_i),
    .sdi_owned_o(sdi_owned_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
  sprs_peer peer (.sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
    .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i), .rx_byte_o(peer_rx));
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; always leaves an idle cycle before the next
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    check("ack", 32'(n < 50), 32'h0000_0001);
  endtask
  // control write, then let the one-cycle irq lag pass
  task automatic ctl(input logic [31:0] d);
    wb(1'b1, SPRS_CTRL_OFS, d);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(nm, q, exp);
  endtask
  // poll the done flag under a bound
  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (q[6] !== 1'b1 && n < 200) begin
      wb(1'b0, SPRS_STAT_OFS, 32'h0000_0000);
      n++;
    end
    check("done", 32'(q[6]), 32'h0000_0001);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // framed mode is never set, so its ignored field stays 0
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl_rst", SPRS_CTRL_OFS, 32'h0000_0000);
    rd("unmapped", 4'hC, 32'h0000_0000);
    ctl(32'h0000_0020); // host, still off
    check("oe_off", 32'(sck_oe_o), 32'h0000_0000);
    ctl(32'h0000_802C); // on, tx select 11, rx select 00
    check("oe_host", 32'(sck_oe_o), 32'h0000_0001);
    check("sdi_own", 32'(sdi_owned_o), 32'h0000_0001);
    check("tx11", 32'(tx_irq_o), 32'h0000_0001);
    ctl(32'h0000_8008); // clearing host while on is ignored
    rd("lock", SPRS_CTRL_OFS, 32'h0000_8028);
    check("tx10", 32'(tx_irq_o), 32'h0000_0001);
    ctl(32'h0000_8024);
    check("tx01", 32'(tx_irq_o), 32'h0000_0001);
    ctl(32'h0000_8021); // tx 00 before any word went out
    check("tx00_idle", 32'(tx_irq_o), 32'h0000_0000);
    peer.load(8'h3C);
    wb(1'b1, SPRS_DATA_OFS, 32'h0000_00A5);
    wait_done();
    repeat (2) @(posedge clk_i);
    check("host_out", 32'(peer_rx), 32'h0000_00A5);
    check("tx00_done", 32'(tx_irq_o), 32'h0000_0001);
    check("rx01", 32'(rx_irq_o), 32'h0000_0001);
    ctl(32'h0000_802F);
    check("rx11_one", 32'(rx_irq_o), 32'h0000_0000);
    ctl(32'h0000_802E);
    check("rx10", 32'(rx_irq_o), 32'h0000_0001);
    ctl(32'h0000_802C);
    rd("rx_word", SPRS_DATA_OFS, 32'h0000_003C);
    hit = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      hit = hit | rx_irq_o;
    end
    check("rx00_pulse", 32'(hit), 32'h0000_0001);
    ctl(32'h0000_0000); // the idle cycle after this write
    ctl(32'h0000_2020); // audio with idle polarity 0
    ctl(32'h0000_A020);
    check("audio_idle", 32'(sck_o), 32'h0000_0001);
    ctl(32'h0000_A03C); // release the serial input, tx select 11
    check("tx11_on", 32'(tx_irq_o), 32'h0000_0001);
    check("sdi_rel", 32'(sdi_owned_o), 32'h0000_0000);
    ctl(32'h0000_0000);
    check("off_irq", 32'(tx_irq_o), 32'h0000_0000);
    ctl(32'h0000_0001); // target role, rx select 01
    ctl(32'h0000_800D); // on, tx select 11
    check("oe_tgt", 32'(sck_oe_o), 32'h0000_0000);
    // an unselected target keeps both words, filling the buffer
    wb(1'b1, SPRS_DATA_OFS, 32'h0000_005A);
    wb(1'b1, SPRS_DATA_OFS, 32'h0000_00C3);
    repeat (2) @(posedge clk_i);
    check("tx11_full", 32'(tx_irq_o), 32'h0000_0000);
    ctl(32'h0000_8009);
    check("tx10_full", 32'(tx_irq_o), 32'h0000_0000);
    ctl(32'h0000_8005);
    check("tx01_full", 32'(tx_irq_o), 32'h0000_0000);
    peer.load(8'h96);
    peer.target_frame();
    repeat (10) @(posedge clk_i);
    check("tgt_out", 32'(peer_rx), 32'h0000_005A);
    check("tgt_irq", 32'(rx_irq_o), 32'h0000_0001);
    rd("tgt_in", SPRS_DATA_OFS, 32'h0000_0096);
    complete_run();
  end
endmodule
